// file: rflc_regs.vh
// Constants of the receive frame length checker
`ifndef RFLC_REGS_VH
`define RFLC_REGS_VH

// Frame framing bytes
`define RFLC_PREAMBLE_BYTE 8'h55
`define RFLC_SFD_BYTE 8'hd5

// Frame length limits, in bytes
`define RFLC_MIN_FRAME 16'h0040
`define RFLC_MAX_FRAME_RST 16'h05ee
`define RFLC_TAG1_EXTRA 16'h0004
`define RFLC_TAG2_EXTRA 16'h0008
`define RFLC_TRUNC_SLACK 16'h000b
`define RFLC_FCS_LEN 16'h0004

// Header geometry
`define RFLC_TYPE0_POS 16'h000c
`define RFLC_TYPE1_POS 16'h0010
`define RFLC_TYPE2_POS 16'h0014
`define RFLC_HDR_BASIC 16'h000e
`define RFLC_HDR_TAG1 16'h0012
`define RFLC_HDR_TAG2 16'h0016
`define RFLC_TPID 16'h8100

// Payload length limits, in bytes
`define RFLC_PAY_MIN_BASIC 16'h002e
`define RFLC_PAY_MIN_TAG1 16'h002a
`define RFLC_PAY_MIN_TAG2 16'h0026
`define RFLC_PAY_LIMIT 16'h0600

// Error vector bit positions
`define RFLC_ERR_LEN_BUF 1
`define RFLC_ERR_LEN_NOBUF 0
`define RFLC_ERR_TRUNC 3

// Nominal latencies in cycles, buffered gigabit cut-through
`define RFLC_TX_LATENCY 38
`define RFLC_RX_LATENCY 99

`endif

// file: rflc_packer.v
// Byte to 32-bit word packer with optional two-byte head alignment
module rflc_packer (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Byte side
  input wire byte_valid,
  input wire byte_first,
  input wire [7:0] byte_data,
  input wire frame_end,
  input wire [3:0] end_error,
  input wire align_en,
  // Word side
  output reg word_valid_ff,
  output reg [31:0] word_data_ff,
  output reg word_sop_ff,
  output reg word_eop_ff,
  output reg [1:0] word_empty_ff,
  output reg [3:0] word_error_ff
);
  reg [31:0] acc_ff;
  reg [2:0] fill_ff;
  reg acc_sop_ff;
  reg [31:0] nxt_acc;
  reg [2:0] nxt_fill;

  // Fill starts at 2 when aligning, leaving two zero lanes on top
  always @*
  begin
    nxt_acc = acc_ff;
    nxt_fill = fill_ff;
    if (byte_first)
    begin
      nxt_acc = 32'h0000_0000;
      nxt_fill = align_en ? 3'd2 : 3'd0;
    end
    else if (fill_ff == 3'd4)
    begin
      nxt_acc = 32'h0000_0000;
      nxt_fill = 3'd0;
    end
    // Without alignment the first byte lands in the most significant lane
    case (nxt_fill[1:0])
      2'd0: nxt_acc[31:24] = byte_data;
      2'd1: nxt_acc[23:16] = byte_data;
      2'd2: nxt_acc[15:8] = byte_data;
      default: nxt_acc[7:0] = byte_data;
    endcase
    nxt_fill = nxt_fill + 3'd1;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      acc_ff <= 32'h0000_0000;
      fill_ff <= 3'd0;
      acc_sop_ff <= 1'b0;
      word_valid_ff <= 1'b0;
      word_data_ff <= 32'h0000_0000;
      word_sop_ff <= 1'b0;
      word_eop_ff <= 1'b0;
      word_empty_ff <= 2'd0;
      word_error_ff <= 4'h0;
    end
    else
    begin
      word_valid_ff <= 1'b0;
      word_sop_ff <= 1'b0;
      word_eop_ff <= 1'b0;
      word_error_ff <= 4'h0;
      if (byte_valid)
      begin
        acc_ff <= nxt_acc;
        fill_ff <= nxt_fill;
        acc_sop_ff <= byte_first | (acc_sop_ff & (fill_ff != 3'd4));
        // A full word leaves only once the next byte proves it is not last
        if (fill_ff == 3'd4 && !byte_first)
        begin
          word_valid_ff <= 1'b1;
          word_data_ff <= acc_ff;
          word_sop_ff <= acc_sop_ff;
          word_empty_ff <= 2'd0;
        end
      end
      else if (frame_end)
      begin
        word_valid_ff <= 1'b1;
        word_data_ff <= acc_ff;
        word_sop_ff <= acc_sop_ff;
        word_eop_ff <= 1'b1;
        word_error_ff <= end_error;
        word_empty_ff <= (fill_ff == 3'd0) ? 2'd3 : 2'd3 - (fill_ff[1:0] - 2'd1);
        fill_ff <= 3'd0;
        acc_sop_ff <= 1'b0;
      end
    end
  end
endmodule

// file: rflc_rx_check.v
// Receive frame length checker, framing stripper and stream writer
`include "rflc_regs.vh"

module rflc_rx_check #(
  parameter BUFFERED = 1,
  parameter LEVEL_W = 16,
  parameter BUF_DEPTH = 2048
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Network side byte interface
  input wire rx_dv,
  input wire [7:0] rxd,
  // Configuration
  input wire [15:0] max_frame_len,
  input wire payload_check_disable,
  input wire pad_remove_en,
  input wire crc_forward,
  input wire rx_align_en,
  // Streaming or buffer write interface
  output wire out_valid,
  output wire [31:0] out_data,
  output wire out_sop,
  output wire out_eop,
  output wire [1:0] out_empty,
  output wire [3:0] out_error,
  input wire out_ready,
  // Buffer level and thresholds
  input wire [LEVEL_W-1:0] buf_level,
  input wire [LEVEL_W-1:0] thr_almost_empty,
  input wire [LEVEL_W-1:0] thr_almost_full,
  input wire [LEVEL_W-1:0] thr_section_empty,
  input wire [LEVEL_W-1:0] thr_section_full,
  output reg almost_empty_ff,
  output reg almost_full_ff,
  output reg section_empty_ff,
  output reg section_full_ff,
  // Status
  output reg drop_mode_ff,
  output reg len_err_seen_ff
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_PRE = 5'b00010;
  localparam ST_DATA = 5'b00100;
  localparam ST_FLUSH = 5'b01000;
  localparam ST_SKIP = 5'b10000;
  localparam [LEVEL_W-1:0] DEPTH_W = BUF_DEPTH[LEVEL_W-1:0];

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [15:0] cnt_ff;
  reg [15:0] type0_ff;
  reg [15:0] type1_ff;
  reg [15:0] type2_ff;
  reg [7:0] dly_ff [0:3];
  reg [2:0] flush_ff;
  reg [15:0] flush_idx_ff;
  reg end_err_len_ff;
  reg sink_fail;

  // Byte stream into packer
  reg pk_valid;
  reg pk_first;
  reg [7:0] pk_data;
  reg pk_end;
  reg [3:0] pk_err;

  // Header classification
  wire tag1 = (type0_ff == `RFLC_TPID);
  wire tag2 = tag1 && (type1_ff == `RFLC_TPID);
  wire [15:0] client_len = tag2 ? type2_ff : (tag1 ? type1_ff : type0_ff);
  wire [15:0] hdr_len = tag2 ? `RFLC_HDR_TAG2 : (tag1 ? `RFLC_HDR_TAG1 : `RFLC_HDR_BASIC);
  wire [15:0] max_len = max_frame_len
    + (tag2 ? `RFLC_TAG2_EXTRA : (tag1 ? `RFLC_TAG1_EXTRA : 16'h0000));
  wire [15:0] pay_min = tag2 ? `RFLC_PAY_MIN_TAG2
    : (tag1 ? `RFLC_PAY_MIN_TAG1 : `RFLC_PAY_MIN_BASIC);
  wire is_len_field = client_len < `RFLC_PAY_LIMIT;
  wire [15:0] cnt_inc = cnt_ff + 16'h0001;
  // Cut only once the count passes the limit plus slack
  wire over_trunc = cnt_inc > (max_len + `RFLC_TRUNC_SLACK);
  wire frame_len_bad = (cnt_ff < `RFLC_MIN_FRAME) || (cnt_ff > max_len);
  wire [15:0] pay_count = cnt_ff - hdr_len - `RFLC_FCS_LEN;
  wire pay_bad = !payload_check_disable && is_len_field
    && ((pay_count != client_len)
    || (client_len < pay_min));
  wire len_err_now = frame_len_bad || pay_bad;
  wire keep_fcs = crc_forward && !pad_remove_en;
  // Pad removal drops the FCS as well
  wire pad_cut = pad_remove_en && is_len_field && (client_len < pay_min);
  wire [15:0] data_end = hdr_len + client_len;
  wire [15:0] emit_idx = cnt_ff - `RFLC_FCS_LEN;
  wire emit_keep = !(pad_cut && (emit_idx >= data_end));
  wire flush_keep = !(pad_cut && (flush_idx_ff >= data_end));

  // Flag bit layout differs between buffered and streamed variants
  function [3:0] err_vec;
    input len_bad;
    input trunc;
    begin
      err_vec = 4'h0;
      if (BUFFERED != 0)
        err_vec[`RFLC_ERR_LEN_BUF] = len_bad;
      else
        err_vec[`RFLC_ERR_LEN_NOBUF] = len_bad;
      err_vec[`RFLC_ERR_TRUNC] = trunc;
      if (BUFFERED != 0)
        err_vec[0] = err_vec[0] | trunc;
    end
  endfunction

  // Not-ready sink while a word is offered
  always @*
  begin
    sink_fail = out_valid && !out_ready;
  end

  always @*
  begin
    nxt_state = state_ff;
    pk_valid = 1'b0;
    pk_first = 1'b0;
    pk_data = dly_ff[3];
    pk_end = 1'b0;
    pk_err = 4'h0;
    case (state_ff)
      ST_IDLE:
      begin
        if (rx_dv && rxd == `RFLC_PREAMBLE_BYTE)
          nxt_state = ST_PRE;
      end
      ST_PRE:
      begin
        // Preamble and delimiter never reach the stream
        if (!rx_dv)
          nxt_state = ST_IDLE;
        else if (rxd == `RFLC_SFD_BYTE)
          nxt_state = ST_DATA;
        else if (rxd != `RFLC_PREAMBLE_BYTE)
          nxt_state = ST_SKIP;
      end
      ST_DATA:
      begin
        if (drop_mode_ff && BUFFERED == 0)
        begin
          // Dropped frames still report one errored end
          if (!rx_dv)
          begin
            pk_end = 1'b1;
            pk_err = err_vec(1'b0, 1'b1);
            nxt_state = ST_IDLE;
          end
        end
        else if (sink_fail)
        begin
          pk_end = 1'b1;
          pk_err = err_vec(1'b0, 1'b1);
          nxt_state = rx_dv ? ST_SKIP : ST_IDLE;
        end
        else if (rx_dv && over_trunc)
        begin
          pk_end = 1'b1;
          pk_err = err_vec(1'b1, 1'b1);
          nxt_state = ST_SKIP;
        end
        else if (rx_dv)
        begin
          pk_valid = (cnt_ff >= `RFLC_FCS_LEN) && emit_keep;
          pk_first = (cnt_ff == `RFLC_FCS_LEN);
        end
        else if (keep_fcs && cnt_ff >= `RFLC_FCS_LEN)
          nxt_state = ST_FLUSH;
        else
        begin
          pk_end = 1'b1;
          pk_err = err_vec(len_err_now, 1'b0);
          nxt_state = ST_IDLE;
        end
      end
      ST_FLUSH:
      begin
        if (sink_fail)
        begin
          pk_end = 1'b1;
          pk_err = err_vec(end_err_len_ff, 1'b1);
          nxt_state = ST_IDLE;
        end
        else if (flush_ff == 3'd4)
        begin
          pk_end = 1'b1;
          pk_err = err_vec(end_err_len_ff, 1'b0);
          nxt_state = ST_IDLE;
        end
        else
        begin
          pk_valid = flush_keep;
          pk_first = (flush_idx_ff == 16'h0000);
          pk_data = dly_ff[3 - flush_ff[1:0]];
        end
      end
      ST_SKIP:
      begin
        // Refused or cut frame ignored until the link idles
        if (!rx_dv)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  integer i;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      type0_ff <= 16'h0000;
      type1_ff <= 16'h0000;
      type2_ff <= 16'h0000;
      flush_ff <= 3'd0;
      flush_idx_ff <= 16'h0000;
      end_err_len_ff <= 1'b0;
      drop_mode_ff <= 1'b0;
      len_err_seen_ff <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        dly_ff[i] <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      // Unbuffered variant drops every later frame until reset
      if (sink_fail && BUFFERED == 0)
        drop_mode_ff <= 1'b1;
      // Sticky record of any length error
      if (pk_end && pk_err[BUFFERED != 0 ? `RFLC_ERR_LEN_BUF : `RFLC_ERR_LEN_NOBUF])
        len_err_seen_ff <= 1'b1;
      // Fresh count and header fields for each frame
      if (state_ff == ST_PRE)
      begin
        cnt_ff <= 16'h0000;
        type0_ff <= 16'h0000;
        type1_ff <= 16'h0000;
        type2_ff <= 16'h0000;
      end
      if (state_ff == ST_DATA && rx_dv)
      begin
        cnt_ff <= cnt_inc;
        dly_ff[0] <= rxd;
        for (i = 1; i < 4; i = i + 1)
          dly_ff[i] <= dly_ff[i-1];
        if (cnt_ff == `RFLC_TYPE0_POS)
          type0_ff[15:8] <= rxd;
        if (cnt_ff == `RFLC_TYPE0_POS + 16'h0001)
          type0_ff[7:0] <= rxd;
        if (cnt_ff == `RFLC_TYPE1_POS)
          type1_ff[15:8] <= rxd;
        if (cnt_ff == `RFLC_TYPE1_POS + 16'h0001)
          type1_ff[7:0] <= rxd;
        if (cnt_ff == `RFLC_TYPE2_POS)
          type2_ff[15:8] <= rxd;
        if (cnt_ff == `RFLC_TYPE2_POS + 16'h0001)
          type2_ff[7:0] <= rxd;
      end
      // Freeze the verdict before the trailing bytes drain
      if (state_ff == ST_DATA && nxt_state == ST_FLUSH)
      begin
        end_err_len_ff <= len_err_now;
        flush_ff <= 3'd0;
        flush_idx_ff <= emit_idx;
      end
      else if (state_ff == ST_FLUSH)
      begin
        flush_ff <= flush_ff + 3'd1;
        flush_idx_ff <= flush_idx_ff + 16'h0001;
      end
    end
  end

  // Thresholds count bytes for 8-bit or words for 32-bit buffers
  always @(posedge mclk)
  begin
    if (rst)
    begin
      almost_empty_ff <= 1'b0;
      almost_full_ff <= 1'b0;
      section_empty_ff <= 1'b0;
      section_full_ff <= 1'b0;
    end
    else if (BUFFERED != 0)
    begin
      almost_empty_ff <= (buf_level <= thr_almost_empty);
      almost_full_ff <= (DEPTH_W - buf_level) <= thr_almost_full;
      section_empty_ff <= buf_level >= thr_section_empty;
      section_full_ff <= (thr_section_full != {LEVEL_W{1'b0}})
        && (buf_level >= thr_section_full);
    end
  end

  // Buffer write or direct stream depending on the variant
  rflc_packer u_packer (
    .mclk(mclk),
    .rst(rst),
    .byte_valid(pk_valid),
    .byte_first(pk_first),
    .byte_data(pk_data),
    .frame_end(pk_end),
    .end_error(pk_err),
    .align_en(rx_align_en),
    .word_valid_ff(out_valid),
    .word_data_ff(out_data),
    .word_sop_ff(out_sop),
    .word_eop_ff(out_eop),
    .word_empty_ff(out_empty),
    .word_error_ff(out_error)
  );

  // Nominal latency figures are kept as RFLC_TX/RX_LATENCY
endmodule

// file: rflc_regs_dummy_guard_note.v
// Holds no logic; the receive path lives in its two design modules

// file: rflc_rx_check_properties.sv
// Port-level property checker for the receive frame length checker
module rflc_rx_check_properties #(
  parameter BUFFERED = 1,
  parameter LEVEL_W = 16
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Watched ports
  input wire rx_dv,
  input wire out_valid,
  input wire out_sop,
  input wire out_eop,
  input wire [3:0] out_error,
  input wire out_ready,
  input wire [LEVEL_W-1:0] buf_level,
  input wire [LEVEL_W-1:0] thr_almost_empty,
  input wire [LEVEL_W-1:0] thr_section_full,
  input wire almost_empty_ff,
  input wire section_full_ff,
  input wire drop_mode_ff,
  input wire len_err_seen_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_link_idle;
    !rx_dv [*8];
  endsequence
  sequence s_stall;
    out_valid && !out_eop && !out_ready;
  endsequence
  sequence s_trunc_end;
    out_valid && out_eop && out_error[3];
  endsequence
  a_sop_has_valid: assert property (out_sop |-> out_valid)
    else $error("start marker without a valid word");
  a_error_at_end: assert property (out_error != 4'h0 |-> out_valid && out_eop)
    else $error("error bits outside the end word");
  a_len_err_sticky: assert property (
    out_valid && out_eop && out_error[BUFFERED ? 1 : 0] |=> len_err_seen_ff)
    else $error("length error not recorded");
  a_idle_quiet: assert property (s_link_idle |-> !out_valid)
    else $error("word output long after the frame ended");
  a_stall_truncates: assert property (s_stall |-> ##[1:2] s_trunc_end)
    else $error("stalled frame not ended with truncation");
  a_no_drop_buf: assert property (BUFFERED != 0 |-> !drop_mode_ff)
    else $error("drop mode in buffered variant");
  a_almost_empty_lvl: assert property (
    !$past(rst) |-> almost_empty_ff ==
    (BUFFERED != 0 && $past(buf_level) <= $past(thr_almost_empty)))
    else $error("almost empty flag wrong");
  a_section_full_lvl: assert property (
    !$past(rst) |-> section_full_ff == (BUFFERED != 0 && $past(thr_section_full) != 0
    && $past(buf_level) >= $past(thr_section_full)))
    else $error("section full flag wrong");
endmodule

bind rflc_rx_check rflc_rx_check_properties #(.BUFFERED(BUFFERED), .LEVEL_W(LEVEL_W)) u_props (
  .mclk(mclk), .rst(rst), .rx_dv(rx_dv), .out_valid(out_valid), .out_sop(out_sop),
  .out_eop(out_eop), .out_error(out_error), .out_ready(out_ready), .buf_level(buf_level),
  .thr_almost_empty(thr_almost_empty), .thr_section_full(thr_section_full),
  .almost_empty_ff(almost_empty_ff), .section_full_ff(section_full_ff),
  .drop_mode_ff(drop_mode_ff), .len_err_seen_ff(len_err_seen_ff)
);

// file: rflc_phy_model.sv
// Network side byte source model
`include "rflc_regs.vh"
module rflc_phy_model (
  // Clock
  input wire mclk,
  // Byte link
  output logic rx_dv,
  output logic [7:0] rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_dv = 1'b0;
    rxd = 8'h00;
  end
  // Header fields at their byte positions, counting bytes elsewhere
  function automatic logic [7:0] frame_byte(input int i, input logic [15:0] lt, ct, c2);
    case (i)
      12: return lt[15:8];
      13: return lt[7:0];
      16: return ct[15:8];
      17: return ct[7:0];
      20: return c2[15:8];
      21: return c2[7:0];
      default: return i[7:0];
    endcase
  endfunction
  task automatic send(input int len, input logic [15:0] lt, ct, c2);
    for (int i = -8; i < len; i++)
    begin
      @(negedge mclk);
      rx_dv = 1'b1;
      rxd = (i < -1) ? `RFLC_PREAMBLE_BYTE
        : (i == -1) ? `RFLC_SFD_BYTE : frame_byte(i, lt, ct, c2);
    end
    // Idle data keeps changing so no stale byte is seen
    for (int i = 0; i < 9; i++)
    begin
      @(negedge mclk);
      rx_dv = 1'b0;
      rxd = ~rxd;
    end
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the receive frame length checker
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic payload_check_disable = 1'b0, pad_remove_en = 1'b0, crc_forward = 1'b0;
  logic rx_align_en = 1'b0, out_ready = 1'b1, rx_dv;
  logic [7:0] rxd;
  logic [15:0] max_frame_len = 16'h0064, buf_level = 16'h0000;
  logic [15:0] thr_ae = 16'h0001, thr_af = 16'h07fe, thr_se = 16'h0003, thr_sf = 16'h0002;
  wire out_valid, out_sop, out_eop, ae_ff, af_ff, se_ff, sf_ff, drop_ff, len_ff;
  wire [31:0] out_data;
  wire [1:0] out_empty;
  wire [3:0] out_error;
  wire nb_valid, nb_eop, nb_drop, nb_len;
  wire [3:0] nb_error;
  logic [31:0] first_word;
  logic [31:0] last_data;
  logic [3:0] last_err;
  logic [3:0] nb_err;
  logic [1:0] last_empty;
  int nb_eops = 0;
  int eop_cnt = 0;
  int mismatches = 0;
  int samples_checked = 0;

  always #12.5 mclk = ~mclk;

  rflc_phy_model u_phy (.mclk(mclk), .rx_dv(rx_dv), .rxd(rxd));
  rflc_rx_check dut (
    .mclk(mclk), .rst(rst), .rx_dv(rx_dv), .rxd(rxd), .max_frame_len(max_frame_len),
    .payload_check_disable(payload_check_disable), .pad_remove_en(pad_remove_en),
    .crc_forward(crc_forward), .rx_align_en(rx_align_en), .out_valid(out_valid),
    .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .out_empty(out_empty),
    .out_error(out_error), .out_ready(out_ready), .buf_level(buf_level),
    .thr_almost_empty(thr_ae), .thr_almost_full(thr_af), .thr_section_empty(thr_se),
    .thr_section_full(thr_sf), .almost_empty_ff(ae_ff), .almost_full_ff(af_ff),
    .section_empty_ff(se_ff), .section_full_ff(sf_ff), .drop_mode_ff(drop_ff),
    .len_err_seen_ff(len_ff)
  );
  // Unbuffered variant sees the same link and sink
  rflc_rx_check #(.BUFFERED(0)) dut_nb (
    .mclk(mclk), .rst(rst), .rx_dv(rx_dv), .rxd(rxd), .max_frame_len(max_frame_len),
    .payload_check_disable(payload_check_disable), .pad_remove_en(pad_remove_en),
    .crc_forward(crc_forward), .rx_align_en(rx_align_en), .out_valid(nb_valid),
    .out_data(), .out_sop(), .out_eop(nb_eop), .out_empty(), .out_error(nb_error),
    .out_ready(out_ready), .buf_level(buf_level), .thr_almost_empty(thr_ae),
    .thr_almost_full(thr_af), .thr_section_empty(thr_se), .thr_section_full(thr_sf),
    .almost_empty_ff(), .almost_full_ff(), .section_empty_ff(), .section_full_ff(),
    .drop_mode_ff(nb_drop), .len_err_seen_ff(nb_len)
  );

  // Record first word and end word of each frame
  always @(posedge mclk)
    if (out_valid && out_sop)
      first_word <= out_data;
  always @(posedge mclk)
    if (out_valid && out_eop)
    begin
      last_err <= out_error;
      last_empty <= out_empty;
      last_data <= out_data;
      eop_cnt <= eop_cnt + 1;
    end
  always @(posedge mclk)
    if (nb_valid && nb_eop)
    begin
      nb_err <= nb_error;
      nb_eops <= nb_eops + 1;
    end

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run(input string what, input int len, input logic [3:0] err,
    input logic [15:0] lt, ct = 16'h0000, c2 = 16'h0000, input logic [3:0] mask = 4'he);
    int n;
    n = eop_cnt;
    u_phy.send(len, lt, ct, c2);
    for (int i = 0; i < 20 && eop_cnt == n; i++)
      @(negedge mclk);
    check(what, {27'h0, eop_cnt != n, last_err & mask}, {27'h0, 1'b1, err});
  endtask

  task automatic t_levels;
    for (int l = 0; l < 4; l++)
    begin
      buf_level = 16'(l);
      @(negedge mclk);
      check("almost_empty", 32'(ae_ff), 32'(l <= 1));
      check("almost_full", 32'(af_ff), 32'(l >= 2));
      check("section_empty", 32'(se_ff), 32'(l >= 3));
      check("section_full", 32'(sf_ff), 32'(l >= 2));
    end
  endtask

  task automatic t_lengths;
    run("short", 63, 4'h2, 16'h002d);
    check("nb_short", 32'(nb_err), 32'h0000_0001);
    run("min_ok", 64, 4'h0, 16'h002e);
    run("pay_mismatch", 64, 4'h2, 16'h002f);
    run("tag_min", 64, 4'h0, 16'h8100, 16'h002a);
    run("stack_min", 64, 4'h0, 16'h8100, 16'h8100, 16'h0026);
    payload_check_disable = 1'b1;
    run("pay_off", 64, 4'h0, 16'h002f);
    run("short_off", 63, 4'h2, 16'h002d);
    payload_check_disable = 1'b0;
    run("basic_max", 100, 4'h0, 16'h0800);
    run("basic_over", 101, 4'h2, 16'h0800);
    run("tag_max", 104, 4'h0, 16'h8100, 16'h0800);
    run("tag_over", 105, 4'h2, 16'h8100, 16'h0800);
    run("stack_max", 108, 4'h0, 16'h8100, 16'h8100, 16'h0800);
    run("stack_over", 109, 4'h2, 16'h8100, 16'h8100, 16'h0800);
    run("near_trunc", 111, 4'h2, 16'h0800);
    run("trunc", 112, 4'ha, 16'h0800);
    check("nb_trunc", 32'(nb_err), 32'h0000_0009);
    check("len_seen", {30'h0, nb_len, len_ff}, 32'h0000_0003);
  endtask

  task automatic t_layout;
    crc_forward = 1'b1;
    run("plain", 64, 4'h0, 16'h002e);
    check("first_word", first_word, 32'h0001_0203);
    check("fcs_kept", 32'(last_empty), 32'h0000_0000);
    check("fcs_bytes", last_data, 32'h3c3d_3e3f);
    crc_forward = 1'b0;
    rx_align_en = 1'b1;
    run("aligned", 64, 4'h0, 16'h002e);
    check("aligned_word", first_word, 32'h0000_0001);
    rx_align_en = 1'b0;
    pad_remove_en = 1'b1;
    run("pad_cut", 64, 4'h2, 16'h0010);
    check("pad_empty", 32'(last_empty), 32'h0000_0002);
    pad_remove_en = 1'b0;
  endtask

  task automatic t_stall;
    int n;
    fork
      run("stall", 100, 4'h8, 16'h0800, 16'h0000, 16'h0000, 4'h8);
      begin
        repeat (40) @(negedge mclk);
        out_ready = 1'b0;
        repeat (4) @(negedge mclk);
        out_ready = 1'b1;
      end
    join
    check("nb_stall", 32'(nb_err), 32'h0000_0008);
    check("drop_modes", {30'h0, nb_drop, drop_ff}, 32'h0000_0002);
    n = nb_eops;
    run("after_stall", 64, 4'h0, 16'h002e);
    check("nb_drop_eops", 32'(nb_eops - n), 32'h0000_0001);
    check("nb_drop_err", 32'(nb_err), 32'h0000_0008);
  endtask

  task automatic conclude;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_levels;
    t_lengths;
    t_layout;
    t_stall;
    conclude;
  end

  initial
  begin
    #250000;
    mismatches++;
    conclude;
  end
endmodule
